// *** logic/sar_readout_pkg.sv ***
// Constants shared by the serial readout sequencer.
// Assumes a single core clock; bit clock and chip select arrive as pins.
`default_nettype none
package sar_readout_pkg;
    localparam int RESULT_WIDTH = 16;
    localparam logic [3:0] TOP_BIT = 4'hF;
    localparam logic [3:0] BOTTOM_BIT = 4'h0;
    // Falling bit-clock edges spent sampling before the null bit
    localparam logic [2:0] SAMPLE_FALLS = 3'h5;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // Core clock and the host's shortest bit-clock phase
    localparam int CORE_CLK_NS = 100;
    localparam int BIT_PHASE_MIN_NS = 200;
    localparam int BIT_PHASE_MIN_CYCLES =
        (BIT_PHASE_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SAMPLE  = 3'b001,
        ST_CONVERT = 3'b010,
        ST_REVERSE = 3'b011,
        ST_FINAL   = 3'b100,
        ST_DONE    = 3'b101
    } seq_state_t;
endpackage : sar_readout_pkg
`default_nettype wire

// *** logic/sar_adc_serial_readout.sv ***
// Serial readout and conversion sequencer of a 16-bit SAR converter.
// Bit clock, chip select and the digitised analog level come from pins
// and are synchronised to core_clk; the bit clock must be well below it.
// How it works
// - Chip select, bit clock in; data out
// - Data changes only on bit-clock falling edges
// - Chip select falling starts a conversion
// - Sample input for about five periods
// - After fifth falling edge, drive low null
// - Then sixteen result bits, MSB first
// - Further clocks repeat result, LSB first
// - After repeated MSB, tri-state and ignore
// - New conversion needs chip select high, low
// - Result is unsigned straight binary
// - No offset or two's-complement coding
// - Power down when done or deselected
`timescale 1ns/1ns
`default_nettype none
module sar_adc_serial_readout (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic serial_bit_clock,
    input wire logic [sar_readout_pkg::RESULT_WIDTH-1:0] analog_level,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    output logic power_down
);
    import sar_readout_pkg::*;

    logic cs_meta;
    logic cs_n_sync;
    logic cs_n_prev;
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic [RESULT_WIDTH-1:0] level_meta;
    logic [RESULT_WIDTH-1:0] level_sync;
    logic cs_fall;
    logic fall_pulse;
    logic rise_pulse;
    seq_state_t state;
    logic [2:0] fall_count;
    logic [3:0] bit_idx;
    logic [RESULT_WIDTH-1:0] held;
    logic [RESULT_WIDTH-1:0] result;

    // Comparator trial: keep the bit if the held level reaches the trial
    // code; the code stays a plain unsigned magnitude throughout.
    function automatic logic decide(input logic [15:0] level,
                                    input logic [15:0] partial,
                                    input logic [3:0] idx);
        logic [15:0] trial;
        trial = partial | (16'h0001 << idx);
        return level >= trial;
    endfunction : decide

    // Pins pass two flops before anything looks at them. The level word
    // is synced bit by bit, so it must hold steady while sampling runs.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cs_meta <= 1'b1;
            cs_n_sync <= 1'b1;
            cs_n_prev <= 1'b1;
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
            level_meta <= RESULT_RESET;
            level_sync <= RESULT_RESET;
        end else begin
            cs_meta <= chip_select_n;
            cs_n_sync <= cs_meta;
            cs_n_prev <= cs_n_sync;
            clk_meta <= serial_bit_clock;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
            level_meta <= analog_level;
            level_sync <= level_meta;
        end
    end

    assign cs_fall = cs_n_prev && !cs_n_sync;
    assign fall_pulse = clk_prev && !clk_sync;
    assign rise_pulse = !clk_prev && clk_sync;

    // Sequencer; the bit clock is the only time base of a conversion
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            fall_count <= 3'h0;
            bit_idx <= TOP_BIT;
            held <= RESULT_RESET;
            result <= RESULT_RESET;
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
        end else if (cs_n_sync) begin
            state <= ST_IDLE;
            serial_data_oe_n <= 1'b1;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Only a fresh falling edge starts; low alone does not
                    if (cs_fall) begin
                        state <= ST_SAMPLE;
                        fall_count <= 3'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (fall_pulse) begin
                        fall_count <= fall_count + 3'h1;
                        if (fall_count == SAMPLE_FALLS - 3'h1) begin
                            held <= level_sync;
                            result <= RESULT_RESET;
                            bit_idx <= TOP_BIT;
                            serial_data_out <= 1'b0;
                            serial_data_oe_n <= 1'b0;
                            state <= ST_CONVERT;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (rise_pulse) begin
                        result[bit_idx] <= decide(held, result, bit_idx);
                    end else if (fall_pulse) begin
                        serial_data_out <= result[bit_idx];
                        if (bit_idx == BOTTOM_BIT) begin
                            bit_idx <= BOTTOM_BIT + 4'h1;
                            state <= ST_REVERSE;
                        end else begin
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                ST_REVERSE: begin
                    if (fall_pulse) begin
                        serial_data_out <= result[bit_idx];
                        if (bit_idx == TOP_BIT) begin
                            state <= ST_FINAL;
                        end else begin
                            bit_idx <= bit_idx + 4'h1;
                        end
                    end
                end
                ST_FINAL: begin
                    if (fall_pulse) begin
                        serial_data_oe_n <= 1'b1;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Later edges are ignored until chip select rises
                    state <= ST_DONE;
                end
                default: begin
                    state <= ST_IDLE;
                    serial_data_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Analog section rests whenever no conversion is running
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            power_down <= 1'b1;
        end else begin
            power_down <= (state == ST_IDLE) || (state == ST_DONE);
        end
    end

    property p_change_on_fall;
        @(posedge core_clk) disable iff (reset)
        $changed(serial_data_out) |-> $past(fall_pulse);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall)
        else $error("data changed without a bit-clock falling edge");

    property p_cs_fall_starts;
        @(posedge core_clk) disable iff (reset)
        (state == ST_IDLE && cs_fall) |=> state == ST_SAMPLE;
    endproperty
    a_cs_fall_starts: assert property (p_cs_fall_starts)
        else $error("chip select fall did not start sampling");

    property p_sample_length;
        @(posedge core_clk) disable iff (reset)
        state == ST_SAMPLE |-> fall_count < SAMPLE_FALLS;
    endproperty
    a_sample_length: assert property (p_sample_length)
        else $error("sampling ran past five falling edges");

    property p_null_bit;
        @(posedge core_clk) disable iff (reset)
        (state == ST_SAMPLE && fall_pulse && !cs_n_sync
            && fall_count == 3'h4)
        |=> (!serial_data_oe_n && !serial_data_out && state == ST_CONVERT);
    endproperty
    a_null_bit: assert property (p_null_bit)
        else $error("null bit not driven low after fifth falling edge");

    property p_msb_first;
        @(posedge core_clk) disable iff (reset)
        (state == ST_CONVERT && fall_pulse && !cs_n_sync)
        |=> (serial_data_out == $past(result[bit_idx])
            && bit_idx != $past(bit_idx));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("forward result bit wrong");

    property p_reverse;
        @(posedge core_clk) disable iff (reset)
        (state == ST_REVERSE && fall_pulse && !cs_n_sync)
        |=> serial_data_out == $past(result[bit_idx]);
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("reverse result bit wrong");

    property p_done_released;
        @(posedge core_clk) disable iff (reset)
        state == ST_DONE |-> serial_data_oe_n ##1 power_down;
    endproperty
    a_done_released: assert property (p_done_released)
        else $error("output driven or powered after completion");

    property p_no_restart;
        @(posedge core_clk) disable iff (reset)
        (state == ST_DONE && !cs_n_sync) |=> state == ST_DONE;
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("left completion without chip select high");

    property p_code_matches;
        @(posedge core_clk) disable iff (reset)
        (state == ST_CONVERT && fall_pulse && bit_idx == BOTTOM_BIT)
        |-> result == held;
    endproperty
    a_code_matches: assert property (p_code_matches)
        else $error("result is not the straight binary held level");

    property p_abort;
        @(posedge core_clk) disable iff (reset)
        cs_n_sync |=> (state == ST_IDLE && serial_data_oe_n) ##1 power_down;
    endproperty
    a_abort: assert property (p_abort)
        else $error("chip select high did not abort");
endmodule : sar_adc_serial_readout
`default_nettype wire

// *** dv/sar_host_model.sv ***
// Host side of the three-wire link: chip select, bit clock, capture.
// Assumes the caller steps it from the core clock's falling edge.
`timescale 1ns/1ns
`default_nettype none
module sar_host_model (
    input wire logic core_clk,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n,
    output logic chip_select_n,
    output logic serial_bit_clock,
    output logic got,
    output logic got_bit
);
    initial begin
        chip_select_n = 1'b1;
        serial_bit_clock = 1'b0;
        got = 1'b0;
        got_bit = 1'b0;
    end
    // Clock idles low; it stands still outside frames
    task automatic run(input int n, input int half);
        chip_select_n = 1'b0;
        repeat (half) @(negedge core_clk);
        for (int r = 1; r <= n; r++) begin
            serial_bit_clock = 1'b1;
            // A released line shows no stale value: model it inverted
            got_bit = serial_data_oe_n ? !serial_data_out
                : serial_data_out;
            got = !serial_data_oe_n;
            @(negedge core_clk);
            got = 1'b0;
            repeat (half - 1) @(negedge core_clk);
            serial_bit_clock = 1'b0;
            repeat (half) @(negedge core_clk);
        end
    endtask : run
    task automatic cs_high();
        chip_select_n = 1'b1;
    endtask : cs_high
endmodule : sar_host_model
`default_nettype wire

// *** dv/sar_adc_serial_readout_tb_top.sv ***
// Self-checking bench for the serial readout sequencer.
// Assumes the host model drives the link; a queue holds expected bits.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_serial_readout_tb_top;
    import sar_readout_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] analog_level = 16'h0000;
    logic [15:0] codes [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
    wire cs_n, sclk, dout, oe_n, pd, got, got_bit;
    int fails = 0;
    int comparisons = 0;
    int seed = 32'h979C;
    logic q [$];
    always #50 core_clk = ~core_clk;
    sar_adc_serial_readout dut (.core_clk(core_clk), .reset(reset),
        .chip_select_n(cs_n), .serial_bit_clock(sclk),
        .analog_level(analog_level), .serial_data_out(dout),
        .serial_data_oe_n(oe_n), .power_down(pd));
    sar_host_model host (.core_clk(core_clk), .serial_data_out(dout),
        .serial_data_oe_n(oe_n), .chip_select_n(cs_n),
        .serial_bit_clock(sclk), .got(got), .got_bit(got_bit));
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic e, input logic s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", name, e, s);
        end
    endtask : check
    task automatic check_bit(input logic e, input logic s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("mismatch serial bit expected %b seen %b", e, s);
        end
    endtask : check_bit
    // Every captured bit must match the oldest expected one
    always @(posedge core_clk) begin
        if (got === 1'b1) begin
            if (q.size() == 0)
                check("oe_n", 1'b1, 1'b0);
            else
                check_bit(q.pop_front(), got_bit);
        end
    end
    // Phases of 500 to 800 ns keep clear of the pin synchroniser
    task automatic frame(input logic [15:0] v, input int n);
        int half;
        half = 5 + int'($unsigned($random(seed)) % 4);
        analog_level = v;
        for (int r = 6; r <= n && r <= 37; r++)
            q.push_back(r == 6 ? 1'b0 : r <= 22 ? v[22 - r] : v[r - 22]);
        host.run(n, half);
        repeat (6) @(negedge core_clk);
        check("power_down", n >= 37, pd);
        check("oe_n", !(n >= 5 && n < 37), oe_n);
        host.cs_high();
        repeat (6) @(negedge core_clk);
        check("oe_n", 1'b1, oe_n);
        check("power_down", 1'b1, pd);
        check("pending bits", 1'b1, q.size() == 0);
    endtask : frame
    initial begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        check("oe_n", 1'b1, oe_n);
        check("power_down", 1'b1, pd);
        foreach (codes[i])
            frame(codes[i], 40);
        frame(16'($random(seed)), 37);
        frame(16'($random(seed)), 12);
        frame(16'($random(seed)), 4);
        frame(16'($random(seed)), 45);
        frame(16'($random(seed)), 22);
        summarize();
    end
    initial begin
        repeat (50000) @(posedge core_clk);
        fails++;
        summarize();
    end
endmodule : sar_adc_serial_readout_tb_top
`default_nettype wire
